// file: rtl/traverse_defs.svh
`ifndef TRAVERSE_DEFS_SVH
`define TRAVERSE_DEFS_SVH
// ==========================================
// timing
`define CLK_PERIOD_NS 10
`define TICK_TIME_NS 100000000
// ==========================================
// register offsets
`define CTRL_OFS 8'h00
`define PRESET_FREQ_OFS 8'h04
`define WAIT_TIME_OFS 8'h08
`define AMP_PCT_OFS 8'h0c
`define JUMP_PCT_OFS 8'h10
`define RISE_TIME_OFS 8'h14
`define FALL_TIME_OFS 8'h18
`define CENTER_SET_OFS 8'h1c
`define GEN_FREQ_OFS 8'h20
`define MAX_FREQ_OFS 8'h24
`define PID_SET_OFS 8'h28
`define STATUS_OFS 8'h2c
`define FREQ_OUT_OFS 8'h30
`define STAGE_TIME_BASE 8'h40
`define STAGE_FREQ_BASE 8'h80
// ==========================================
// control fields and codes
`define MODE_MSB 1
`define MODE_LSB 0
`define VAR_AMP_BIT 4
`define SRC_SEL_BIT 8
`define PID_MODE_BIT 9
`define SEQ_EN_BIT 10
`define MODE_OFF 2'h0
`define MODE_ALWAYS 2'h1
`define MODE_TERM 2'h2
`define NUM_STAGES 15
`define LAST_STAGE 4'he
`define LAST_PID_STAGE 4'h6
`define PCT_SCALE 34'h00000003e8
// ==========================================
// reset values
`define CTRL_RST 16'h0000
`define PRESET_FREQ_RST 16'h03e8
`define WAIT_TIME_RST 16'h0000
`define AMP_PCT_RST 16'h0064
`define JUMP_PCT_RST 16'h0064
`define RISE_TIME_RST 16'h0064
`define FALL_TIME_RST 16'h0064
`define CENTER_SET_RST 16'h03e8
`define GEN_FREQ_RST 16'h0000
`define MAX_FREQ_RST 16'h1388
`define PID_SET_RST 16'h0000
`define STAGE_FREQ_RST 16'h01f4
`endif

// file: rtl/traverse_pkg.sv
package traverse_pkg;
  typedef logic [15:0] freq_type;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_preset = 4'b0010,
    st_rise = 4'b0100,
    st_fall = 4'b1000
  } swing_state_type;
endpackage

// file: rtl/profile_if.sv
`timescale 1ns/1ps
interface profile_if;
  import traverse_pkg::*;
  freq_type general_freq, max_freq, center_set, pid_setpoint, cfg_data;
  logic [15:0] amp_pct, jump_pct;
  logic var_amp, src_sel, pid_mode, seq_en, run, tick, cfg_wr;
  logic [7:0] cfg_addr;
  freq_type upper, lower, jump, center, base_ref;
  logic [3:0] stage;
  modport core(output general_freq, max_freq, center_set, pid_setpoint, amp_pct, jump_pct,
    var_amp, src_sel, pid_mode, seq_en, run, tick, cfg_wr, cfg_addr, cfg_data,
    input upper, lower, jump, center, base_ref, stage);
  modport math(input general_freq, max_freq, center_set, amp_pct, jump_pct, var_amp,
    output upper, lower, jump, center);
  modport seq(input src_sel, pid_mode, seq_en, run, tick, general_freq, pid_setpoint,
    cfg_wr, cfg_addr, cfg_data, output base_ref, stage);
endinterface

// file: rtl/swing_bounds.sv
`timescale 1ns/1ps
`include "traverse_defs.svh"
module swing_bounds import traverse_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  profile_if.math ifc
);
  logic [16:0] center_sum, amp_base, hi_sum, jmp_sum;
  logic [15:0] center_val;
  logic [33:0] amp_full, jmp_full;
  assign center_sum = {1'b0, ifc.center_set} + {1'b0, ifc.general_freq};
  // bounds are built from the same centre that is registered, so all three move together
  assign center_val = center_sum[16] ? 16'hffff : center_sum[15:0];
  assign amp_base = ifc.var_amp ? center_sum : {1'b0, ifc.max_freq};
  assign amp_full = (34'(ifc.amp_pct) * 34'(amp_base)) / `PCT_SCALE;
  assign jmp_full = (34'(ifc.jump_pct) * 34'(ifc.upper - ifc.center)) / `PCT_SCALE;
  assign hi_sum = {1'b0, center_val} + 17'(amp_full[15:0]);
  assign jmp_sum = 17'(jmp_full[15:0]);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ifc.center <= 16'h0000;
      ifc.upper <= 16'h0000;
      ifc.lower <= 16'h0000;
      ifc.jump <= 16'h0000;
    end else begin
      ifc.center <= center_val;
      ifc.upper <= hi_sum[16] ? 16'hffff : hi_sum[15:0];
      ifc.lower <= (amp_full[15:0] < center_val) ? center_val - amp_full[15:0] : 16'h0000;
      ifc.jump <= jmp_sum[15:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  bounds_order_a: assert property (##1 ifc.lower <= ifc.center && ifc.center <= ifc.upper)
    else $error("swing bounds not ordered around centre");
  center_sum_a: assert property (##1 $stable(center_sum) |=>
    ifc.center == $past(center_sum[15:0]) || $past(center_sum[16]))
    else $error("centre differs from setting plus command");
endmodule // swing_bounds

// file: rtl/stage_sequencer.sv
`timescale 1ns/1ps
`include "traverse_defs.svh"
module stage_sequencer import traverse_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  profile_if.seq ifc
);
  logic [15:0] run_time [`NUM_STAGES];
  freq_type preset_freq [`NUM_STAGES];
  logic [15:0] elapsed;
  logic [3:0] last;
  logic stage_done;
  // ==========================================
  // per-stage settings
  genvar i;
  for (i = 0; i < `NUM_STAGES; i++) begin : g_stage
    always_ff @(posedge core_clk) begin
      if (rst) begin
        run_time[i] <= 16'h0000;
        preset_freq[i] <= `STAGE_FREQ_RST;
      end else if (ifc.cfg_wr && ifc.cfg_addr == `STAGE_TIME_BASE + 8'(4 * i)) begin
        run_time[i] <= ifc.cfg_data;
      end else if (ifc.cfg_wr && ifc.cfg_addr == `STAGE_FREQ_BASE + 8'(4 * i)) begin
        preset_freq[i] <= ifc.cfg_data;
      end
    end
  end
  // ==========================================
  // stage stepping; a zero-time stage costs one clock, so all-zero just spins
  assign last = ifc.pid_mode ? `LAST_PID_STAGE : `LAST_STAGE;
  assign stage_done = run_time[ifc.stage] == 16'h0000 ||
    (ifc.tick && elapsed + 16'h0001 >= run_time[ifc.stage]);
  always_ff @(posedge core_clk) begin
    if (rst || !ifc.run || !ifc.seq_en) begin
      ifc.stage <= 4'h0;
      elapsed <= 16'h0000;
    end else if (stage_done) begin
      ifc.stage <= (ifc.stage >= last) ? 4'h0 : ifc.stage + 4'h1;
      elapsed <= 16'h0000;
    end else if (ifc.tick) begin
      elapsed <= elapsed + 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ifc.base_ref <= 16'h0000;
    end else if (ifc.seq_en && !ifc.src_sel) begin
      // a zero-time stage keeps the previous target, so it never reaches the output
      if (run_time[ifc.stage] != 16'h0000) begin
        ifc.base_ref <= preset_freq[ifc.stage];
      end
    end else begin
      ifc.base_ref <= ifc.pid_mode ? ifc.pid_setpoint : ifc.general_freq;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  zero_skip_a: assert property (ifc.run && ifc.seq_en && run_time[ifc.stage] == 16'h0000
    |=> ifc.stage != $past(ifc.stage))
    else $error("zero-time stage was not skipped");
  preset_src_a: assert property (ifc.seq_en && !ifc.src_sel && run_time[ifc.stage] != 16'h0000
    |=> ifc.base_ref == $past(preset_freq[ifc.stage]))
    else $error("stage target not taken from preset table");
  zero_hold_a: assert property (ifc.seq_en && !ifc.src_sel && run_time[ifc.stage] == 16'h0000
    |=> $stable(ifc.base_ref))
    else $error("zero-time stage reached the target");
  stage_wrap_c: cover property (ifc.stage == last ##1 ifc.stage == 4'h0);
endmodule // stage_sequencer

// file: rtl/traverse_frequency_profile_gen.sv
// Operation
// - stage source picks preset or general command
// - zero running time stage is skipped
// - mode 1 swings under priority, 0 off
// - mode 2 swings on terminal, else preset
// - mode 1: preset held for wait time
// - fixed amplitude: percent times maximum frequency
// - variable amplitude: percent times centre sum
// - jump down at upper, up at lower
// - jump equals jump percent times amplitude
// - rise spans lower to upper in rise time
// - fall spans upper to lower in fall time
// - centre is centre setting plus command
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "traverse_defs.svh"
module traverse_frequency_profile_gen import traverse_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic run_cmd,
  input wire logic freq_priority,
  input wire logic swing_terminal,
  output logic [15:0] freq_ref,
  output logic swing_active
);
  profile_if ifc();
  logic [15:0] ctrl;
  freq_type swing_preset_frequency, swing_center_setting;
  freq_type general_frequency_command, maximum_output_frequency, pid_setpoint_value;
  logic [15:0] preset_wait_time, swing_amplitude_pct, jump_pct;
  logic [15:0] triangle_rise_time, triangle_fall_time;
  logic [1:0] mode;
  logic [31:0] tick_cnt;
  logic tick;
  swing_state_type state;
  freq_type cur_freq;
  logic [15:0] wait_cnt;
  logic [47:0] acc, rise_den, fall_den, span_w;
  logic swing_ok, term_hold, at_upper, at_lower;
  freq_type drop_val, raise_val;
  logic [16:0] raise_sum;

  // ==========================================
  // register file
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= `CTRL_RST;
      swing_preset_frequency <= `PRESET_FREQ_RST;
      preset_wait_time <= `WAIT_TIME_RST;
      swing_amplitude_pct <= `AMP_PCT_RST;
      jump_pct <= `JUMP_PCT_RST;
      triangle_rise_time <= `RISE_TIME_RST;
      triangle_fall_time <= `FALL_TIME_RST;
      swing_center_setting <= `CENTER_SET_RST;
      general_frequency_command <= `GEN_FREQ_RST;
      maximum_output_frequency <= `MAX_FREQ_RST;
      pid_setpoint_value <= `PID_SET_RST;
    end else if (wr) begin
      if (addr == `CTRL_OFS) begin
        ctrl <= wdata[15:0];
      end else if (addr == `PRESET_FREQ_OFS) begin
        swing_preset_frequency <= wdata[15:0];
      end else if (addr == `WAIT_TIME_OFS) begin
        preset_wait_time <= wdata[15:0];
      end else if (addr == `AMP_PCT_OFS) begin
        swing_amplitude_pct <= wdata[15:0];
      end else if (addr == `JUMP_PCT_OFS) begin
        jump_pct <= wdata[15:0];
      end else if (addr == `RISE_TIME_OFS) begin
        triangle_rise_time <= wdata[15:0];
      end else if (addr == `FALL_TIME_OFS) begin
        triangle_fall_time <= wdata[15:0];
      end else if (addr == `CENTER_SET_OFS) begin
        swing_center_setting <= wdata[15:0];
      end else if (addr == `GEN_FREQ_OFS) begin
        general_frequency_command <= wdata[15:0];
      end else if (addr == `MAX_FREQ_OFS) begin
        maximum_output_frequency <= wdata[15:0];
      end else if (addr == `PID_SET_OFS) begin
        pid_setpoint_value <= wdata[15:0];
      end
    end
  end

  // read data live for exactly the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst || !rd) begin
      rdata <= 32'h00000000;
    end else if (addr == `CTRL_OFS) begin
      rdata <= {16'h0000, ctrl};
    end else if (addr == `PRESET_FREQ_OFS) begin
      rdata <= {16'h0000, swing_preset_frequency};
    end else if (addr == `WAIT_TIME_OFS) begin
      rdata <= {16'h0000, preset_wait_time};
    end else if (addr == `AMP_PCT_OFS) begin
      rdata <= {16'h0000, swing_amplitude_pct};
    end else if (addr == `JUMP_PCT_OFS) begin
      rdata <= {16'h0000, jump_pct};
    end else if (addr == `RISE_TIME_OFS) begin
      rdata <= {16'h0000, triangle_rise_time};
    end else if (addr == `FALL_TIME_OFS) begin
      rdata <= {16'h0000, triangle_fall_time};
    end else if (addr == `CENTER_SET_OFS) begin
      rdata <= {16'h0000, swing_center_setting};
    end else if (addr == `GEN_FREQ_OFS) begin
      rdata <= {16'h0000, general_frequency_command};
    end else if (addr == `MAX_FREQ_OFS) begin
      rdata <= {16'h0000, maximum_output_frequency};
    end else if (addr == `PID_SET_OFS) begin
      rdata <= {16'h0000, pid_setpoint_value};
    end else if (addr == `STATUS_OFS) begin
      rdata <= {20'h00000, ifc.stage, 4'h0, state};
    end else if (addr == `FREQ_OUT_OFS) begin
      rdata <= {16'h0000, freq_ref};
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // ==========================================
  // sub-blocks
  assign mode = ctrl[`MODE_MSB:`MODE_LSB];
  assign ifc.general_freq = general_frequency_command;
  assign ifc.max_freq = maximum_output_frequency;
  assign ifc.center_set = swing_center_setting;
  assign ifc.pid_setpoint = pid_setpoint_value;
  assign ifc.amp_pct = swing_amplitude_pct;
  assign ifc.jump_pct = jump_pct;
  assign ifc.var_amp = ctrl[`VAR_AMP_BIT];
  assign ifc.src_sel = ctrl[`SRC_SEL_BIT];
  assign ifc.pid_mode = ctrl[`PID_MODE_BIT];
  assign ifc.seq_en = ctrl[`SEQ_EN_BIT];
  assign ifc.run = run_cmd;
  assign ifc.tick = tick;
  assign ifc.cfg_wr = wr && addr >= `STAGE_TIME_BASE;
  assign ifc.cfg_addr = addr;
  assign ifc.cfg_data = wdata[15:0];

  swing_bounds u_bounds (
    .core_clk(core_clk),
    .rst(rst),
    .ifc(ifc.math)
  );
  stage_sequencer u_seq (
    .core_clk(core_clk),
    .rst(rst),
    .ifc(ifc.seq)
  );

  // ==========================================
  // 0.1 s time base
  always_ff @(posedge core_clk) begin
    if (rst || tick) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end
  assign tick = tick_cnt >= TICK_CYCLES - 1;

  // ==========================================
  // swing control
  assign swing_ok = freq_priority && (mode == `MODE_ALWAYS ||
    (mode == `MODE_TERM && swing_terminal));
  assign term_hold = freq_priority && mode == `MODE_TERM && !swing_terminal;
  assign at_upper = cur_freq >= ifc.upper;
  assign at_lower = cur_freq <= ifc.lower;
  assign drop_val = (ifc.upper > ifc.jump) ? ifc.upper - ifc.jump : 16'h0000;
  assign raise_sum = {1'b0, ifc.lower} + {1'b0, ifc.jump};
  assign raise_val = raise_sum[16] ? 16'hffff : raise_sum[15:0];
  // slope as a rate: span steps spread over time * tick cycles
  assign span_w = 48'(ifc.upper - ifc.lower);
  assign rise_den = 48'(triangle_rise_time) * 48'(TICK_CYCLES);
  assign fall_den = 48'(triangle_fall_time) * 48'(TICK_CYCLES);

  always_ff @(posedge core_clk) begin
    if (rst || !run_cmd) begin
      state <= st_idle;
    end else if (!swing_ok) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          // terminal mode skips the wait entirely
          state <= (mode == `MODE_TERM) ? st_rise : st_preset;
        end
        st_preset: begin
          if (wait_cnt >= preset_wait_time) begin
            state <= st_rise;
          end
        end
        st_rise: begin
          if (at_upper) begin
            state <= st_fall;
          end
        end
        st_fall: begin
          if (at_lower) begin
            state <= st_rise;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || state != st_preset) begin
      wait_cnt <= 16'h0000;
    end else if (tick && wait_cnt != 16'hffff) begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  // a zero ramp time reaches the boundary at once
  // at most one step per clock: a span wider than ramp time in clocks ramps too slowly
  always_ff @(posedge core_clk) begin
    if (rst || state == st_idle || state == st_preset) begin
      cur_freq <= ifc.center;
      acc <= 48'h000000000000;
    end else if (state == st_rise) begin
      if (at_upper) begin
        cur_freq <= drop_val;
        acc <= 48'h000000000000;
      end else if (rise_den == 48'h000000000000) begin
        cur_freq <= ifc.upper;
      end else if (acc + span_w >= rise_den) begin
        acc <= acc + span_w - rise_den;
        cur_freq <= cur_freq + 16'h0001;
      end else begin
        acc <= acc + span_w;
      end
    end else begin
      if (at_lower) begin
        cur_freq <= raise_val;
        acc <= 48'h000000000000;
      end else if (fall_den == 48'h000000000000) begin
        cur_freq <= ifc.lower;
      end else if (acc + span_w >= fall_den) begin
        acc <= acc + span_w - fall_den;
        cur_freq <= cur_freq - 16'h0001;
      end else begin
        acc <= acc + span_w;
      end
    end
  end

  // ==========================================
  // output frequency
  always_ff @(posedge core_clk) begin
    if (rst || !run_cmd) begin
      freq_ref <= 16'h0000;
    end else if ((state == st_rise || state == st_fall) && swing_ok) begin
      freq_ref <= cur_freq;
    end else if (swing_ok || term_hold) begin
      freq_ref <= swing_preset_frequency;
    end else begin
      freq_ref <= ifc.base_ref;
    end
  end
  assign swing_active = state == st_rise || state == st_fall;

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  mode_off_a: assert property (run_cmd && mode == `MODE_OFF |=>
    freq_ref == $past(ifc.base_ref) && state == st_idle)
    else $error("swing active or output wrong with function off");
  term_preset_a: assert property (run_cmd && term_hold |=>
    freq_ref == $past(swing_preset_frequency) && !swing_active)
    else $error("terminal released but preset not output");
  term_direct_a: assert property (state == st_idle && run_cmd && swing_ok &&
    mode == `MODE_TERM |=> state == st_rise)
    else $error("terminal mode did not bypass the wait");
  preset_entry_a: assert property (state == st_idle && run_cmd && swing_ok &&
    mode == `MODE_ALWAYS |=> state == st_preset ##1 freq_ref == swing_preset_frequency
    || !run_cmd || !swing_ok)
    else $error("always mode did not start at preset");
  preset_hold_a: assert property (state == st_preset && run_cmd && swing_ok &&
    wait_cnt < preset_wait_time |=> state == st_preset)
    else $error("preset left before wait time");
  upper_jump_a: assert property (state == st_rise && at_upper && run_cmd && swing_ok
    |=> state == st_fall && cur_freq == $past(drop_val))
    else $error("no jump down at upper boundary");
  lower_jump_a: assert property (state == st_fall && at_lower && run_cmd && swing_ok
    |=> state == st_rise && cur_freq == $past(raise_val))
    else $error("no jump up at lower boundary");
  rise_dir_a: assert property (state == st_rise && !at_upper && rise_den != 48'h0 &&
    run_cmd && swing_ok |=> cur_freq - $past(cur_freq) <= 16'h0001)
    else $error("rise ramp moved by more than one step");
  fall_dir_a: assert property (state == st_fall && !at_lower && fall_den != 48'h0 &&
    run_cmd && swing_ok |=> $past(cur_freq) - cur_freq <= 16'h0001)
    else $error("fall ramp moved by more than one step");
  swing_out_a: assert property (swing_active && swing_ok && run_cmd |=>
    freq_ref == $past(cur_freq))
    else $error("output not following triangle");
  rise_fall_c: cover property (state == st_rise ##1 state == st_fall);
  fall_rise_c: cover property (state == st_fall ##1 state == st_rise);
  preset_rise_c: cover property (state == st_preset ##1 state == st_rise);
endmodule // traverse_frequency_profile_gen

// file: dv/drive_stage_model.sv
`timescale 1ns/1ps
// ==========================================
// output stage and terminal model
module drive_stage_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] freq_ref,
  input wire logic swing_active,
  input wire logic run_req,
  input wire logic prio_req,
  input wire logic term_req,
  input wire logic clear,
  output logic run_cmd,
  output logic freq_priority,
  output logic swing_terminal,
  output logic [15:0] drop_to,
  output logic [15:0] climb_to,
  output logic [15:0] peak,
  output logic [15:0] climb_len,
  output logic [15:0] fall_len
);
  logic [15:0] last;
  logic [15:0] cnt;

  // terminals are levels; registered so they move just after an edge
  always_ff @(posedge core_clk) begin
    run_cmd <= rst ? 1'b0 : run_req;
    freq_priority <= rst ? 1'b0 : prio_req;
    swing_terminal <= rst ? 1'b0 : term_req;
  end

  // a step wider than 20 counts as a jump; ramp steps here stay well below that
  always_ff @(posedge core_clk) begin
    last <= freq_ref;
    if (rst || clear) begin
      drop_to <= '0;
      climb_to <= '0;
      peak <= '0;
      climb_len <= '0;
      fall_len <= '0;
      cnt <= '0;
    end else if (swing_active) begin
      cnt <= cnt + 16'h0001;
      if (freq_ref > peak) peak <= freq_ref;
      if (last > freq_ref + 16'h0014) begin
        drop_to <= freq_ref;
        climb_len <= cnt;
        cnt <= '0;
      end
      if (freq_ref > last + 16'h0014) begin
        climb_to <= freq_ref;
        fall_len <= cnt;
        cnt <= '0;
      end
    end
  end
endmodule // drive_stage_model

// file: dv/test_traverse_frequency_profile_gen.sv
`timescale 1ns/1ps
`include "traverse_defs.svh"
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module test_traverse_frequency_profile_gen;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] freq_ref;
  logic swing_active, run_cmd, freq_priority, swing_terminal;
  logic run_req = 1'b0;
  logic prio_req = 1'b0;
  logic term_req = 1'b0;
  logic clear = 1'b0;
  logic [15:0] drop_to, climb_to, peak, climb_len, fall_len;
  int fail_count = 0;
  int check_count = 0;
  localparam logic [7:0] rst_ofs [11] = '{`CTRL_OFS, `PRESET_FREQ_OFS, `WAIT_TIME_OFS,
    `AMP_PCT_OFS, `JUMP_PCT_OFS, `RISE_TIME_OFS, `FALL_TIME_OFS, `CENTER_SET_OFS,
    `GEN_FREQ_OFS, `MAX_FREQ_OFS, `PID_SET_OFS};
  localparam logic [15:0] rst_val [11] = '{`CTRL_RST, `PRESET_FREQ_RST, `WAIT_TIME_RST,
    `AMP_PCT_RST, `JUMP_PCT_RST, `RISE_TIME_RST, `FALL_TIME_RST, `CENTER_SET_RST,
    `GEN_FREQ_RST, `MAX_FREQ_RST, `PID_SET_RST};

  always #5 core_clk = ~core_clk;

  // a short tick keeps every 0.1 s count at ten clocks
  traverse_frequency_profile_gen #(.TICK_CYCLES(10)) dut (.core_clk(core_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_cmd(run_cmd),
    .freq_priority(freq_priority), .swing_terminal(swing_terminal), .freq_ref(freq_ref),
    .swing_active(swing_active));

  drive_stage_model far (.core_clk(core_clk), .rst(rst), .freq_ref(freq_ref),
    .swing_active(swing_active), .run_req(run_req), .prio_req(prio_req),
    .term_req(term_req), .clear(clear), .run_cmd(run_cmd), .freq_priority(freq_priority),
    .swing_terminal(swing_terminal), .drop_to(drop_to), .climb_to(climb_to), .peak(peak),
    .climb_len(climb_len), .fall_len(fall_len));

  // ==========================================
  // bus and stimulus helpers
  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= {16'h0000, d};
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task set_run(input logic r, input logic p, input logic t);
    @(posedge core_clk);
    run_req <= r;
    prio_req <= p;
    term_req <= t;
  endtask

  task wait_swing(input logic lvl, input int lim);
    int i;
    i = 0;
    while (swing_active !== lvl && i < lim) begin
      cycles(1);
      i++;
    end
  endtask

  // ==========================================
  // scenarios
  task test_registers;
    logic [31:0] d;
    for (int i = 0; i < 11; i++) begin
      rd_reg(rst_ofs[i], d);
      `CHECK(d, {16'h0000, rst_val[i]})
    end
    rd_reg(8'h3c, d);
    `CHECK(d, 32'h00000000)
    wr_reg(`STAGE_TIME_BASE, 16'h0005);
    rd_reg(`STAGE_TIME_BASE, d);
    `CHECK(d, 32'h00000000)
    wr_reg(`RISE_TIME_OFS, 16'h000a);
    rd_reg(`RISE_TIME_OFS, d);
    `CHECK(d, 32'h0000000a)
    $display("test done: registers");
  endtask

  task test_sequencer;
    int seen [4];
    seen = '{0, 0, 0, 0};
    wr_reg(`STAGE_TIME_BASE, 16'h0002);
    wr_reg(`STAGE_TIME_BASE + 8'h08, 16'h0002);
    wr_reg(`STAGE_FREQ_BASE, 16'h02bc);
    wr_reg(`STAGE_FREQ_BASE + 8'h04, 16'h0320);
    wr_reg(`STAGE_FREQ_BASE + 8'h08, 16'h0384);
    wr_reg(`CTRL_OFS, 16'h0400);
    set_run(1'b1, 1'b1, 1'b0);
    repeat (150) begin
      cycles(1);
      if (freq_ref === 16'h02bc) seen[0]++;
      if (freq_ref === 16'h0384) seen[1]++;
      if (freq_ref === 16'h0320) seen[2]++;
      if (freq_ref === 16'h01f4) seen[3]++;
      if (swing_active !== 1'b0) seen[3]++;
    end
    `CHECK(seen[0] > 0, 1'b1)
    `CHECK(seen[1] > 0, 1'b1)
    `CHECK(seen[2], 0)
    `CHECK(seen[3], 0)
    wr_reg(`GEN_FREQ_OFS, 16'h04d2);
    wr_reg(`CTRL_OFS, 16'h0500);
    cycles(5);
    `CHECK(freq_ref, 16'h04d2)
    wr_reg(`PID_SET_OFS, 16'h0123);
    wr_reg(`CTRL_OFS, 16'h0700);
    cycles(5);
    `CHECK(freq_ref, 16'h0123)
    set_run(1'b0, 1'b0, 1'b0);
    cycles(3);
    `CHECK(freq_ref, 16'h0000)
    $display("test done: sequencer");
  endtask

  // expected bounds are worked out by hand from amplitude and jump percentages;
  // ten-second ramps are 1000 clocks lower to upper, and a jump trims 5% of that
  task test_swing(input logic [15:0] ctrl, input logic [15:0] gen, input logic [15:0] drop,
    input logic [15:0] climb, input logic [15:0] top);
    wr_reg(`GEN_FREQ_OFS, gen);
    wr_reg(`RISE_TIME_OFS, 16'h0064);
    wr_reg(`FALL_TIME_OFS, 16'h0064);
    wr_reg(`WAIT_TIME_OFS, 16'h0002);
    wr_reg(`CTRL_OFS, ctrl);
    @(posedge core_clk);
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    set_run(1'b1, 1'b1, 1'b0);
    cycles(8);
    `CHECK(freq_ref, 16'h03e8)
    `CHECK(swing_active, 1'b0)
    wait_swing(1'b1, 40);
    `CHECK(swing_active, 1'b1)
    cycles(2600);
    `CHECK(drop_to, drop)
    `CHECK(climb_to, climb)
    `CHECK(peak, top)
    `CHECK(climb_len >= 16'd945 && climb_len <= 16'd955, 1'b1)
    `CHECK(fall_len >= 16'd945 && fall_len <= 16'd955, 1'b1)
    set_run(1'b1, 1'b0, 1'b0);
    wait_swing(1'b0, 3);
    `CHECK(swing_active, 1'b0)
    set_run(1'b0, 1'b0, 1'b0);
    cycles(3);
    $display("test done: swing");
  endtask

  task test_terminal;
    logic [31:0] d;
    wr_reg(`WAIT_TIME_OFS, 16'h0005);
    wr_reg(`CTRL_OFS, 16'h0002);
    set_run(1'b1, 1'b1, 1'b0);
    cycles(10);
    `CHECK(freq_ref, 16'h03e8)
    `CHECK(swing_active, 1'b0)
    set_run(1'b1, 1'b1, 1'b1);
    wait_swing(1'b1, 4);
    `CHECK(swing_active, 1'b1)
    set_run(1'b1, 1'b1, 1'b0);
    wait_swing(1'b0, 4);
    `CHECK(swing_active, 1'b0)
    cycles(3);
    `CHECK(freq_ref, 16'h03e8)
    rd_reg(`FREQ_OUT_OFS, d);
    `CHECK(d, 32'h000003e8)
    rd_reg(`STATUS_OFS, d);
    `CHECK(d, 32'h00000001)
    set_run(1'b0, 1'b0, 1'b0);
    $display("test done: terminal");
  endtask

  // ==========================================
  // run control
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    test_registers;
    test_sequencer;
    test_swing(16'h0001, 16'h0000, 16'h05aa, 16'h0226, 16'h05dc);
    test_swing(16'h0011, 16'h07d0, 16'h0cc6, 16'h0aaa, 16'h0ce4);
    test_terminal;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    finish_test;
  end
endmodule // test_traverse_frequency_profile_gen
